// ---- rtl/codec_regs_pkg.sv ----
// register map, field layout and level thresholds of the codec control block
package codec_regs_pkg;

   // ************************************************************
   // register indices (byte address is four times the index)
   // ************************************************************
   localparam int REG_IDX_W = 4;
   localparam logic [REG_IDX_W-1:0] IDX_STATUS = 4'h1;
   localparam logic [REG_IDX_W-1:0] IDX_INPUT = 4'h2;
   localparam logic [REG_IDX_W-1:0] IDX_CTRL = 4'h4;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_STAT = 4'h5;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_MASK = 4'h6;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int STAT_UNDERRUN_BIT = 8;
   localparam int STAT_RIGHT_PEAK_LSB = 2;
   localparam int STAT_LEFT_PEAK_LSB = 0;
   localparam int INP_LEFT_SEL_LSB = 13;
   localparam int INP_LEFT_BOOST_BIT = 12;
   localparam int INP_LEFT_GAIN_LSB = 8;
   localparam int INP_RIGHT_SEL_LSB = 5;
   localparam int INP_RIGHT_BOOST_BIT = 4;
   localparam int INP_RIGHT_GAIN_LSB = 0;
   localparam int CTRL_PDN_REQ_BIT = 0;
   localparam int CTRL_DAC1_EN_BIT = 1;
   localparam int CTRL_ADC_LEFT_EN_BIT = 2;
   localparam int CTRL_ADC_RIGHT_EN_BIT = 3;
   localparam int IRQ_UNDERRUN_BIT = 0;
   localparam int IRQ_LEFT_OVER_BIT = 1;
   localparam int IRQ_RIGHT_OVER_BIT = 2;
   localparam int IRQ_W = 3;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] INPUT_RESET = 16'h0000;
   localparam logic [3:0] CTRL_RESET = 4'h1;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // ************************************************************
   // peak level bands; full scale is 2**15 on an 18-bit adc word
   // ************************************************************
   typedef enum logic [1:0] {
      BAND_UNDER, BAND_NEAR, BAND_OVER, BAND_FAR
   } peak_band_t;
   localparam int ADC_W = 18;
   localparam logic [ADC_W-1:0] MAG_MINUS_1DB = 18'h07215;
   localparam logic [ADC_W-1:0] MAG_FULL_SCALE = 18'h08000;
   localparam logic [ADC_W-1:0] MAG_PLUS_1DB = 18'h08F9E;

endpackage

// ---- rtl/codec_status_input_ctrl.sv ----
// channel status flags and adc input control registers behind an apb slave
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module codec_status_input_ctrl #(
   parameter int ADDR_W = 8,
   parameter int BUF_DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_down_pin_b,
   output logic conversion_powered_down_flag,
   input wire logic dac1_in_valid,
   input wire logic [15:0] dac1_in_left,
   input wire logic [15:0] dac1_in_right,
   output logic dac1_in_ready,
   input wire logic dac1_sample_req,
   output logic [15:0] dac1_out_left,
   output logic [15:0] dac1_out_right,
   input wire logic adc_left_valid,
   input wire logic [codec_regs_pkg::ADC_W-1:0] adc_left_sample,
   input wire logic adc_right_valid,
   input wire logic [codec_regs_pkg::ADC_W-1:0] adc_right_sample,
   output logic [2:0] left_input_selector,
   output logic left_mic_boost,
   output logic [3:0] left_input_gain,
   output logic [2:0] right_input_selector,
   output logic right_mic_boost,
   output logic [3:0] right_input_gain,
   output logic irq
);
   import codec_regs_pkg::*;

   localparam int PTR_W = $clog2(BUF_DEPTH);
   localparam int CNT_W = $clog2(BUF_DEPTH + 1);

   // ************************************************************
   // reset synchroniser
   // ************************************************************
   logic rst_meta_ff;
   logic rst_n;

   // release is synchronous so no flop leaves reset on a split edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   // maps a byte address to a register index; misaligned gives no hit
   function automatic logic [REG_IDX_W:0] decode(logic [ADDR_W-1:0] a);
      logic [REG_IDX_W-1:0] idx;
      logic hit;
      idx = a[REG_IDX_W+1:2];
      hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:REG_IDX_W+2] == '0) &&
            (idx == IDX_STATUS || idx == IDX_INPUT || idx == IDX_CTRL ||
             idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);
      return {hit, idx};
   endfunction

   logic [REG_IDX_W:0] dec;
   logic hit;
   logic [REG_IDX_W-1:0] idx;
   logic setup;
   logic wr_done;
   logic [15:0] wmask;

   assign dec = decode(paddr);
   assign hit = dec[REG_IDX_W];
   assign idx = dec[REG_IDX_W-1:0];
   assign setup = psel && !penable;
   // zero wait states: every access phase completes at once
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign wr_done = psel && penable && pwrite && hit;
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // ************************************************************
   // power state
   // ************************************************************
   logic [3:0] ctrl_ff;
   logic conv_down;
   logic dac1_active;
   logic [1:0] adc_en;

   // flag follows the pin and the request bit with no delay, reading 1 while either asks for power-down
   assign conv_down = !power_down_pin_b || ctrl_ff[CTRL_PDN_REQ_BIT];
   assign conversion_powered_down_flag = conv_down;
   assign dac1_active = ctrl_ff[CTRL_DAC1_EN_BIT] && !conv_down;
   assign adc_en[0] = ctrl_ff[CTRL_ADC_LEFT_EN_BIT];
   assign adc_en[1] = ctrl_ff[CTRL_ADC_RIGHT_EN_BIT];

   // control bits; power-down request comes up set after reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_done && idx == IDX_CTRL && pstrb[0]) begin
         ctrl_ff <= pwdata[3:0];
      end
   end

   // ************************************************************
   // dac1 stereo sample buffer
   // ************************************************************
   logic [15:0] left_mem [BUF_DEPTH];
   logic [15:0] right_mem [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff;
   logic [PTR_W-1:0] rd_ptr_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic push;
   logic pop;
   logic underrun_evt;

   assign dac1_in_ready = dac1_active && (cnt_ff != CNT_W'(BUF_DEPTH));
   assign push = dac1_in_valid && dac1_in_ready;
   assign pop = dac1_active && dac1_sample_req && (cnt_ff != '0);
   assign underrun_evt = dac1_active && dac1_sample_req && !pop;

   // sample storage needs no reset; only pointers carry state
   always_ff @(posedge clk) begin
      if (push) begin
         left_mem[wr_ptr_ff] <= dac1_in_left;
         right_mem[wr_ptr_ff] <= dac1_in_right;
      end
   end

   // pointers; a powered-down dac drops whatever was queued
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else if (!dac1_active) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= PTR_W'((wr_ptr_ff + 1'b1) % BUF_DEPTH);
         end
         if (pop) begin
            rd_ptr_ff <= PTR_W'((rd_ptr_ff + 1'b1) % BUF_DEPTH);
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

   // dac output words; a starved request plays silence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dac1_out_left <= 16'h0000;
         dac1_out_right <= 16'h0000;
      end else if (pop) begin
         dac1_out_left <= left_mem[rd_ptr_ff];
         dac1_out_right <= right_mem[rd_ptr_ff];
      end else if (underrun_evt || !dac1_active) begin
         dac1_out_left <= 16'h0000;
         dac1_out_right <= 16'h0000;
      end
   end

   // ************************************************************
   // channel status flags
   // ************************************************************
   logic stat_clear;
   logic underrun_ff;
   peak_band_t peak_ff [2];
   peak_band_t band_w [2];
   logic [1:0] adc_vld;
   logic [ADC_W-1:0] adc_smp [2];
   logic [15:0] status_word;

   // any read (taken at setup) or any write of the status register
   assign stat_clear = psel && hit && idx == IDX_STATUS &&
                       (pwrite ? penable : !penable);
   assign adc_vld = {adc_right_valid, adc_left_valid};
   assign adc_smp[0] = adc_left_sample;
   assign adc_smp[1] = adc_right_sample;

   // magnitude of a two's complement adc word into a level band
   function automatic peak_band_t band_of(logic [ADC_W-1:0] s);
      logic [ADC_W-1:0] mag;
      mag = s[ADC_W-1] ? ADC_W'(~s + 1'b1) : s;
      if (mag > MAG_PLUS_1DB) begin
         return BAND_FAR;
      end else if (mag > MAG_FULL_SCALE) begin
         return BAND_OVER;
      end else if (mag > MAG_MINUS_1DB) begin
         return BAND_NEAR;
      end
      return BAND_UNDER;
   endfunction

   // underrun flag; a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         underrun_ff <= 1'b0;
      end else if (conv_down) begin
         underrun_ff <= 1'b0;
      end else if (!dac1_active) begin
         underrun_ff <= 1'b0;
      end else if (underrun_evt) begin
         underrun_ff <= 1'b1;
      end else if (stat_clear) begin
         underrun_ff <= 1'b0;
      end
   end

   // one peak recorder per adc channel, index 0 left and 1 right
   for (genvar ch = 0; ch < 2; ch++) begin : g_peak
      peak_band_t base;
      assign band_w[ch] = band_of(adc_smp[ch]);
      assign base = stat_clear ? BAND_UNDER : peak_ff[ch];
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            peak_ff[ch] <= BAND_UNDER;
         end else if (conv_down) begin
            peak_ff[ch] <= BAND_UNDER;
         end else if (!adc_en[ch]) begin
            peak_ff[ch] <= BAND_UNDER;
         end else if (adc_vld[ch] && band_w[ch] > base) begin
            peak_ff[ch] <= band_w[ch];
         end else begin
            peak_ff[ch] <= base;
         end
      end
   end

   always_comb begin
      status_word = STATUS_RESET;
      status_word[STAT_UNDERRUN_BIT] = underrun_ff;
      status_word[STAT_RIGHT_PEAK_LSB +: 2] = peak_ff[1];
      status_word[STAT_LEFT_PEAK_LSB +: 2] = peak_ff[0];
   end

   // ************************************************************
   // adc input control register
   // ************************************************************
   logic [15:0] input_ff;

   // locked at zero while converters are down; byte strobes honoured
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_ff <= INPUT_RESET;
      end else if (conv_down) begin
         input_ff <= INPUT_RESET;
      end else if (wr_done && idx == IDX_INPUT) begin
         input_ff <= (input_ff & ~wmask) | (pwdata[15:0] & wmask);
      end
   end

   // source, boost and gain fields drive the analog front end as coded
   assign left_input_selector = input_ff[INP_LEFT_SEL_LSB +: 3];
   assign right_input_selector = input_ff[INP_RIGHT_SEL_LSB +: 3];
   assign left_mic_boost = input_ff[INP_LEFT_BOOST_BIT];
   assign right_mic_boost = input_ff[INP_RIGHT_BOOST_BIT];
   assign left_input_gain = input_ff[INP_LEFT_GAIN_LSB +: 4];
   assign right_input_gain = input_ff[INP_RIGHT_GAIN_LSB +: 4];

   // ************************************************************
   // interrupts
   // ************************************************************
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] irq_evt;

   assign irq_evt[IRQ_UNDERRUN_BIT] = underrun_evt;
   assign irq_evt[IRQ_LEFT_OVER_BIT] = adc_en[0] && !conv_down &&
                                       adc_vld[0] && band_w[0] >= BAND_OVER;
   assign irq_evt[IRQ_RIGHT_OVER_BIT] = adc_en[1] && !conv_down &&
                                        adc_vld[1] && band_w[1] >= BAND_OVER;

   // write one to clear; an event in the same cycle keeps its bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= IRQ_RESET;
      end else if (wr_done && idx == IDX_IRQ_STAT && pstrb[0]) begin
         irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_evt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_ff <= IRQ_RESET;
      end else if (wr_done && idx == IDX_IRQ_MASK && pstrb[0]) begin
         irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // ************************************************************
   // read data
   // ************************************************************
   // captured at setup so the status value read is the one cleared
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= 32'h0000_0000;
         if (hit && !pwrite) begin
            unique case (idx)
               IDX_STATUS: prdata[15:0] <= status_word;
               IDX_INPUT: prdata[15:0] <= input_ff;
               IDX_CTRL: prdata[3:0] <= ctrl_ff;
               IDX_IRQ_STAT: prdata[IRQ_W-1:0] <= irq_stat_ff;
               IDX_IRQ_MASK: prdata[IRQ_W-1:0] <= irq_mask_ff;
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_starved;
      dac1_active && dac1_sample_req && cnt_ff == '0;
   endsequence

   sequence s_quiet_after;
      ##1 dac1_out_left == 16'h0000 && dac1_out_right == 16'h0000;
   endsequence

   property p_underrun_set;
      @(posedge clk) disable iff (!rst_n) s_starved |=> underrun_ff;
   endproperty
   a_underrun_set: assert property (p_underrun_set)
      else $error("underrun flag not set on starved request");

   property p_zero_fill;
      @(posedge clk) disable iff (!rst_n) s_starved |-> s_quiet_after;
   endproperty
   a_zero_fill: assert property (p_zero_fill)
      else $error("dac1 not fed zeros on underrun");

   property p_underrun_sticky;
      @(posedge clk) disable iff (!rst_n)
         underrun_ff && !stat_clear && dac1_active ##1 dac1_active
         |-> underrun_ff;
   endproperty
   a_underrun_sticky: assert property (p_underrun_sticky)
      else $error("underrun flag dropped without a clear");

   property p_underrun_off;
      @(posedge clk) disable iff (!rst_n)
         !ctrl_ff[CTRL_DAC1_EN_BIT] |=> !underrun_ff;
   endproperty
   a_underrun_off: assert property (p_underrun_off)
      else $error("underrun flag kept with dac1 disabled");

   property p_right_clear;
      @(posedge clk) disable iff (!rst_n)
         stat_clear && !adc_vld[1] |=> peak_ff[1] == BAND_UNDER;
   endproperty
   a_right_clear: assert property (p_right_clear)
      else $error("right peak not cleared by status access");

   property p_right_off;
      @(posedge clk) disable iff (!rst_n) !adc_en[1] |=> peak_ff[1] == 2'h0;
   endproperty
   a_right_off: assert property (p_right_off)
      else $error("right peak kept with right adc disabled");

   property p_band_capture;
      @(posedge clk) disable iff (!rst_n)
         adc_en[0] && !conv_down && adc_vld[0] && !stat_clear &&
         band_w[0] > peak_ff[0] |=> peak_ff[0] == $past(band_w[0]);
   endproperty
   a_band_capture: assert property (p_band_capture)
      else $error("left peak did not take the new band");

   property p_left_clear;
      @(posedge clk) disable iff (!rst_n)
         stat_clear && !adc_vld[0] |=> peak_ff[0] == BAND_UNDER;
   endproperty
   a_left_clear: assert property (p_left_clear)
      else $error("left peak not cleared by status access");

   property p_left_off;
      @(posedge clk) disable iff (!rst_n) !adc_en[0] |=> peak_ff[0] == 2'h0;
   endproperty
   a_left_off: assert property (p_left_off)
      else $error("left peak kept with left adc disabled");

   property p_status_down;
      @(posedge clk) disable iff (!rst_n) conv_down |=> status_word == 16'h0;
   endproperty
   a_status_down: assert property (p_status_down)
      else $error("status not zero in power-down");

   property p_input_down;
      @(posedge clk) disable iff (!rst_n) conv_down |=> input_ff == 16'h0;
   endproperty
   a_input_down: assert property (p_input_down)
      else $error("input control not zero in power-down");

   property p_pdn_flag;
      @(posedge clk) disable iff (!rst_n)
         !power_down_pin_b |-> conversion_powered_down_flag;
   endproperty
   a_pdn_flag: assert property (p_pdn_flag)
      else $error("power-down flag low with pin asserted");

   property p_peak_rise;
      @(posedge clk) disable iff (!rst_n)
         adc_en[1] && !conv_down && !stat_clear
         |=> peak_ff[1] >= $past(peak_ff[1]);
   endproperty
   a_peak_rise: assert property (p_peak_rise)
      else $error("right peak decreased without a clear");

endmodule
`default_nettype wire

// ---- verif/test_codec_status_input_ctrl.sv ----
// self-checking bench for the codec status and input control registers
`timescale 1ns/10ps
`default_nettype none
module test_codec_status_input_ctrl;
   import codec_regs_pkg::*;
   // ****************************************
   // stimulus signals and reference model state
   // ****************************************
   localparam logic [7:0] A_ST = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [7:0] A_IN = {2'b00, IDX_INPUT, 2'b00};
   localparam logic [7:0] A_CT = {2'b00, IDX_CTRL, 2'b00};
   localparam logic [7:0] A_IS = {2'b00, IDX_IRQ_STAT, 2'b00};
   localparam logic [7:0] A_IM = {2'b00, IDX_IRQ_MASK, 2'b00};
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pin_b = 1'b1, dv = 1'b0, dreq = 1'b0;
   logic lv = 1'b0, rv = 1'b0, pready, pslverr, cflag, drdy, irq, err, hold;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, exp_in, seed = 32'h31F4176B;
   logic [3:0] pstrb = '0, lg, rg;
   logic [15:0] dl = '0, dr = '0, ol, orr;
   logic [ADC_W-1:0] ls = '0, rs = '0;
   logic [ADC_W-1:0] edges [6] = '{MAG_MINUS_1DB, MAG_MINUS_1DB + 18'h00001,
      MAG_FULL_SCALE, MAG_FULL_SCALE + 18'h00001, MAG_PLUS_1DB,
      MAG_PLUS_1DB + 18'h00001};
   logic [2:0] lsel, rsel;
   logic lb, rb;
   logic [31:0] q [$];
   int error_cnt = 0, compares = 0, lp = 0, rp = 0, ur = 0;

   // free-running 25 MHz clock
   always #20 clk = ~clk;

   codec_status_input_ctrl codec_status_input_ctrl_inst (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_down_pin_b(pin_b), .conversion_powered_down_flag(cflag),
      .dac1_in_valid(dv), .dac1_in_left(dl), .dac1_in_right(dr),
      .dac1_in_ready(drdy), .dac1_sample_req(dreq), .dac1_out_left(ol),
      .dac1_out_right(orr), .adc_left_valid(lv), .adc_left_sample(ls),
      .adc_right_valid(rv), .adc_right_sample(rs),
      .left_input_selector(lsel), .left_mic_boost(lb),
      .left_input_gain(lg), .right_input_selector(rsel),
      .right_mic_boost(rb), .right_input_gain(rg), .irq(irq));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // peak band of a two's complement sample, by magnitude
   function automatic int band(input logic [ADC_W-1:0] s);
      int m;
      m = int'($signed(s));
      if (m < 0) m = -m;
      if (m > int'(MAG_PLUS_1DB)) return 3;
      if (m > int'(MAG_FULL_SCALE)) return 2;
      return (m > int'(MAG_MINUS_1DB)) ? 1 : 0;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic complete_run;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // one apb transfer; an idle cycle follows so psel is never set twice
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      // the wait ends once pready reads 1; a stalled slave is left to the watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic push(input logic [31:0] v);
      dv <= 1'b1;
      {dl, dr} <= v;
      do begin
         @(posedge clk);
      end while (drdy !== 1'b1);
      dv <= 1'b0;
      q.push_back(v);
      @(posedge clk);
   endtask

   // one dac request; the held output is compared against the model
   task automatic pop;
      dreq <= 1'b1;
      @(posedge clk);
      dreq <= 1'b0;
      repeat (2) @(posedge clk);
      if (q.size() == 0) ur = 1;
      check({ol, orr}, (q.size() > 0) ? q.pop_front() : '0);
   endtask

   task automatic adc(input logic [ADC_W-1:0] l, input logic [ADC_W-1:0] r);
      lv <= 1'b1;
      rv <= 1'b1;
      ls <= l;
      rs <= r;
      @(posedge clk);
      lv <= 1'b0;
      rv <= 1'b0;
      @(posedge clk);
      if (band(l) > lp) lp = band(l);
      if (band(r) > rp) rp = band(r);
   endtask

   // a status read returns the flags, then the register starts afresh
   task automatic stat_chk;
      apb(1'b0, A_ST, '0);
      check(rd, {ur[0], 4'h0, rp[1:0], lp[1:0]});
      ur = 0;
      lp = 0;
      rp = 0;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      check(cflag, 1'b1);
      apb(1'b1, A_IN, 32'h0000FFFF);
      apb(1'b0, A_IN, '0);
      check(rd, '0);
      stat_chk;
      apb(1'b0, 8'hFC, '0);
      check({rd[0], err}, 2'h1);
      apb(1'b1, A_CT, 32'h0000000E);
      check(cflag, 1'b0);
      // every selector code, random gain and boost bits
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         exp_in = {16'h0000, i[2:0], seed[12:8], ~i[2:0], seed[4:0]};
         apb(1'b1, A_IN, exp_in);
         apb(1'b0, A_IN, '0);
         check(rd, exp_in);
         check({lsel, lb, lg, rsel, rb, rg}, exp_in[15:0]);
      end
      // band edges, positive on the left channel and negative on the right
      foreach (edges[i]) begin
         adc(edges[i], -edges[i]);
         stat_chk;
      end
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         adc(seed[17:0], seed[31:14]);
      end
      stat_chk;
      // interrupt raised, masked and cleared
      adc(18'h0A000, '0);
      apb(1'b0, A_IS, '0);
      check(rd[IRQ_LEFT_OVER_BIT], 1'b1);
      apb(1'b1, A_IM, '0);
      hold = irq;
      apb(1'b1, A_IM, 32'h00000007);
      check(hold ^ irq, 1'b1);
      apb(1'b1, A_IS, 32'h00000007);
      check(irq, 1'b0);
      apb(1'b1, A_IM, '0);
      stat_chk;
      // fill the four-deep buffer until refused, drain past empty
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         push(seed);
      end
      check(drdy, 1'b0);
      repeat (5) pop;
      stat_chk;
      // write clears sticky flags and peaks
      pop;
      adc(18'h09000, 18'h37000);
      repeat (4) @(posedge clk);
      apb(1'b1, A_ST, '0);
      apb(1'b0, A_ST, '0);
      check(rd, '0);
      // channel power-down clears its flags
      pop;
      adc(18'h09000, 18'h37000);
      apb(1'b1, A_CT, '0);
      apb(1'b0, A_ST, '0);
      check(rd, '0);
      apb(1'b1, A_CT, 32'h0000000E);
      // request bit clears, pin clears and locks
      apb(1'b1, A_IN, 32'h00005A5A);
      apb(1'b1, A_CT, 32'h0000000F);
      apb(1'b0, A_IN, '0);
      check(rd, '0);
      apb(1'b1, A_CT, 32'h0000000E);
      adc(18'h0A000, 18'h0A000);
      pin_b <= 1'b0;
      repeat (2) @(posedge clk);
      check(cflag, 1'b1);
      apb(1'b1, A_IN, 32'h0000A5A5);
      pin_b <= 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, A_IN, '0);
      check(rd, '0);
      apb(1'b0, A_ST, '0);
      check(rd, '0);
      complete_run;
   end

   // watchdog far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      complete_run;
   end
endmodule
`default_nettype wire
